// ### rtl/p3m_mii_port.sv
`timescale 1ns/1ps
`include "p3m_map.svh"

// Functional notes
// - MII traffic is switch port 3 traffic
// - Separate transmit and receive groups, own clocks
// - Exactly one role: PHY or MAC mode
// - Unencoded nibbles, quarter of bit rate
// - Transmit side qualifies data: valid, error
// - Receive valid marks good nibbles
// - Half duplex collision flagged during transmission
// - No receive/transmit error output driven
// - Errored frames filtered inside, not signalled
// - Bypass exists only in PHY mode
// - PHY mode: transmit error pin is link status
// - Link high: stop forwarding new frames here
// - Link rising: flush frames queued for port
module p3m_mii_port
  import p3m_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       srst_in,
  // Configuration
  input  wire logic       mode_mac_in,
  input  wire logic       half_duplex_in,
  // Transmit group pins (device input side)
  input  wire logic       p3_tx_enable_in,
  input  wire logic       p3_tx_error_in,
  input  wire logic       p3_tx_data_bit3_in,
  input  wire logic       p3_tx_data_bit2_in,
  input  wire logic       p3_tx_data_bit1_in,
  input  wire logic       p3_tx_data_bit0_in,
  input  wire logic       p3_tx_clock_in,
  output logic            p3_tx_clock_out,
  output logic            p3_tx_clock_oe_n_out,
  // Receive group pins (device output side)
  output logic            p3_rx_valid_out,
  output logic            p3_rx_data_bit3_out,
  output logic            p3_rx_data_bit2_out,
  output logic            p3_rx_data_bit1_out,
  output logic            p3_rx_data_bit0_out,
  input  wire logic       p3_rx_clock_in,
  output logic            p3_rx_clock_out,
  output logic            p3_rx_clock_oe_n_out,
  // Collision and carrier sense pins
  input  wire logic       p3_collision_in,
  output logic            p3_collision_out,
  output logic            p3_collision_oe_n_out,
  input  wire logic       p3_carrier_sense_in,
  output logic            p3_carrier_sense_out,
  output logic            p3_carrier_sense_oe_n_out,
  // Ingress stream toward the switch fabric
  output logic            ing_valid_out,
  output logic [3:0]      ing_data_out,
  output logic            ing_frame_out,
  output logic            ing_end_out,
  output logic            ing_error_out,
  // Egress stream from the switch fabric
  input  wire logic       eg_valid_in,
  input  wire logic [3:0] eg_data_in,
  input  wire logic       eg_last_in,
  output logic            eg_ready_out,
  // Bypass and status toward the fabric
  output logic            fwd_block_out,
  output logic            flush_req_out,
  output logic            port_collision_flag_out,
  output logic            carrier_sense_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Constants

  localparam int         HALF_CYC = (`P3M_NIBBLE_PERIOD_NS / `P3M_CORE_PERIOD_NS) / 2;
  localparam logic [2:0] HALF_M1  = 3'(HALF_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [`P3M_PIN_W-1:0] pin_raw;
  logic [`P3M_PIN_W-1:0] pin_sync;

  assign pin_raw = {mode_mac_in, p3_tx_clock_in, p3_rx_clock_in, p3_tx_enable_in,
                    p3_tx_error_in, p3_tx_data_bit3_in, p3_tx_data_bit2_in,
                    p3_tx_data_bit1_in, p3_tx_data_bit0_in, p3_collision_in,
                    p3_carrier_sense_in};

  // Data and clock share the same latency, so their alignment is kept
  p3m_sync2 #(
    .WIDTH (`P3M_PIN_W)
  ) u_pin_sync (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .async_in    (pin_raw),
    .sync_out    (pin_sync)
  );

  logic       mac;
  logic       sy_tx_clk;
  logic       sy_rx_clk;
  logic       sy_tx_en;
  logic       sy_tx_err;
  logic [3:0] sy_tx_data;
  logic       sy_col;
  logic       sy_crs;

  assign mac        = pin_sync[`P3M_PIN_MODE];
  assign sy_tx_clk  = pin_sync[`P3M_PIN_TX_CLK];
  assign sy_rx_clk  = pin_sync[`P3M_PIN_RX_CLK];
  assign sy_tx_en   = pin_sync[`P3M_PIN_TX_EN];
  assign sy_tx_err  = pin_sync[`P3M_PIN_TX_ERR];
  assign sy_tx_data = pin_sync[`P3M_PIN_TX_D_HI:`P3M_PIN_TX_D_LO];
  assign sy_col     = pin_sync[`P3M_PIN_COL];
  assign sy_crs     = pin_sync[`P3M_PIN_CRS];

  ////////////////////////////////////////////////////////////////////////////
  // State

  p3m_state_t s;
  p3m_state_t next_s;

  logic tx_lvl;
  logic rx_lvl;
  logic tx_rise;
  logic rx_fall;
  logic link_lvl;

  always_comb begin
    next_s           = s;
    next_s.ing_valid = 1'b0;
    next_s.ing_end   = 1'b0;
    next_s.flush_req = 1'b0;

    // Nibble clock for PHY mode, the divider runs in both modes
    if (s.div_cnt == HALF_M1) begin
      next_s.div_cnt = `P3M_DIV_RST;
      next_s.clk_gen = ~s.clk_gen;
    end else begin
      next_s.div_cnt = s.div_cnt + 3'h1;
    end

    // Direction clocks: own divider in PHY mode, partner clocks in MAC mode
    tx_lvl          = mac ? sy_tx_clk : s.clk_gen;
    rx_lvl          = mac ? sy_rx_clk : s.clk_gen;
    tx_rise         = tx_lvl & ~s.tx_clk_q;
    rx_fall         = ~rx_lvl & s.rx_clk_q;
    next_s.tx_clk_q = tx_lvl;
    next_s.rx_clk_q = rx_lvl;

    // Link status only has meaning in PHY mode
    link_lvl      = ~mac & sy_tx_err;
    next_s.link_q = link_lvl;
    if (link_lvl && !s.link_q) begin
      next_s.flush_req = 1'b1;
    end

    // Ingress: nibbles taken on the transmit-side rising edge
    if (tx_rise) begin
      if (sy_tx_en) begin
        next_s.ing_valid = 1'b1;
        next_s.ing_data  = sy_tx_data;
        next_s.ing_frame = 1'b1;
        if (mac && sy_tx_err) begin
          // Partner's receive error only marks the frame for dropping
          next_s.err_seen = 1'b1;
        end
      end else if (s.ing_frame) begin
        next_s.ing_frame = 1'b0;
        next_s.ing_end   = 1'b1;
        next_s.ing_error = s.err_seen;
        next_s.err_seen  = 1'b0;
      end
    end

    // Egress: data changes on the falling edge so the partner samples on rise
    case (s.eg_state)
      P3M_EG_IDLE, P3M_EG_SEND: begin
        if (link_lvl) begin
          // Frame in flight is cut short; the partner is powered down anyway
          next_s.rx_valid = 1'b0;
          next_s.eg_state = P3M_EG_FLUSH;
        end else if (rx_fall) begin
          if (eg_valid_in) begin
            next_s.rx_valid = 1'b1;
            next_s.rx_data  = eg_data_in;
            next_s.eg_state = eg_last_in ? P3M_EG_IDLE : P3M_EG_SEND;
          end else begin
            next_s.rx_valid = 1'b0;
            next_s.eg_state = P3M_EG_IDLE;
          end
        end
      end
      P3M_EG_FLUSH: begin
        next_s.rx_valid = 1'b0;
        if (!link_lvl) begin
          next_s.eg_state = P3M_EG_IDLE;
        end
      end
      default: begin
        next_s.rx_valid = 1'b0;
        next_s.eg_state = P3M_EG_IDLE;
      end
    endcase

    // Carrier sense and collision toward an external MAC (PHY mode)
    next_s.crs = sy_tx_en | s.rx_valid;
    next_s.col = half_duplex_in & sy_tx_en & s.rx_valid;

    // Collision seen by port 3 in either role, half duplex only
    next_s.col_flag = half_duplex_in & (mac ? sy_col : (sy_tx_en & s.rx_valid));
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      s <= `P3M_STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Clocks and status pins are driven only in PHY mode
  assign p3_tx_clock_out           = s.clk_gen;
  assign p3_tx_clock_oe_n_out      = mac;
  assign p3_rx_clock_out           = s.clk_gen;
  assign p3_rx_clock_oe_n_out      = mac;
  assign p3_collision_out          = s.col;
  assign p3_collision_oe_n_out     = mac;
  assign p3_carrier_sense_out      = s.crs;
  assign p3_carrier_sense_oe_n_out = mac;

  // No error pin exists on the output side at all
  assign p3_rx_valid_out     = s.rx_valid;
  assign p3_rx_data_bit3_out = s.rx_data[3];
  assign p3_rx_data_bit2_out = s.rx_data[2];
  assign p3_rx_data_bit1_out = s.rx_data[1];
  assign p3_rx_data_bit0_out = s.rx_data[0];

  assign ing_valid_out = s.ing_valid;
  assign ing_data_out  = s.ing_data;
  assign ing_frame_out = s.ing_frame;
  assign ing_end_out   = s.ing_end;
  assign ing_error_out = s.ing_error;

  // Flushing accepts a queued nibble on every core cycle and discards it
  assign eg_ready_out = (s.eg_state == P3M_EG_FLUSH) |
                        (rx_fall & ~link_lvl);

  assign fwd_block_out           = link_lvl;
  assign flush_req_out           = s.flush_req;
  assign port_collision_flag_out = s.col_flag;
  assign carrier_sense_out       = mac ? sy_crs : s.crs;

endmodule

// ### rtl/p3m_map.svh
`ifndef P3M_MAP_SVH
`define P3M_MAP_SVH

// Core clock period and generated nibble clock period, in nanoseconds
`define P3M_CORE_PERIOD_NS   10
`define P3M_NIBBLE_PERIOD_NS 80

// Reset values
`define P3M_STATE_RST        '0
`define P3M_SYNC_RST         '0
`define P3M_DIV_RST          3'h0

// Layout of the synchronised pin vector
`define P3M_PIN_W            11
`define P3M_PIN_MODE         10
`define P3M_PIN_TX_CLK       9
`define P3M_PIN_RX_CLK       8
`define P3M_PIN_TX_EN        7
`define P3M_PIN_TX_ERR       6
`define P3M_PIN_TX_D_HI      5
`define P3M_PIN_TX_D_LO      2
`define P3M_PIN_COL          1
`define P3M_PIN_CRS          0

`endif

// ### rtl/p3m_pkg.sv
package p3m_pkg;

  // Egress sequencer, Gray coded along idle -> send -> flush
  typedef enum logic [1:0] {
    P3M_EG_IDLE  = 2'b00,
    P3M_EG_SEND  = 2'b01,
    P3M_EG_FLUSH = 2'b11
  } p3m_eg_state_t;

  typedef struct packed {
    logic [2:0]    div_cnt;
    logic          clk_gen;
    logic          tx_clk_q;
    logic          rx_clk_q;
    logic          link_q;
    p3m_eg_state_t eg_state;
    logic          rx_valid;
    logic [3:0]    rx_data;
    logic          ing_valid;
    logic [3:0]    ing_data;
    logic          ing_frame;
    logic          ing_end;
    logic          ing_error;
    logic          err_seen;
    logic          crs;
    logic          col;
    logic          col_flag;
    logic          flush_req;
  } p3m_state_t;

endpackage

// ### rtl/p3m_sync2.sv
`timescale 1ns/1ps
`include "p3m_map.svh"

module p3m_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             srst_in,
  // Asynchronous levels and their synchronised copies
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } p3m_sync_state_t;

  p3m_sync_state_t s;
  p3m_sync_state_t next_s;

  // First stage feeds only the second stage
  always_comb begin
    next_s      = s;
    next_s.meta = async_in;
    next_s.sync = s.meta;
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      s <= `P3M_SYNC_RST;
    end else begin
      s <= next_s;
    end
  end

  assign sync_out = s.sync;

endmodule

// ### testbench/p3m_mii_port_chk.sv
`timescale 1ns/1ps

module p3m_mii_port_chk (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic srst_in,
  // Watched ports
  input wire logic half_duplex_in,
  input wire logic p3_tx_clock_oe_n_out,
  input wire logic p3_rx_valid_out,
  input wire logic ing_valid_out,
  input wire logic ing_frame_out,
  input wire logic ing_end_out,
  input wire logic ing_error_out,
  input wire logic eg_ready_out,
  input wire logic fwd_block_out,
  input wire logic flush_req_out,
  input wire logic port_collision_flag_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  AST_NO_BYPASS_MAC: assert property (p3_tx_clock_oe_n_out |-> !fwd_block_out)
    else $error("bypass active in MAC mode");
  AST_FLUSH_AFTER_LINK: assert property ($rose(fwd_block_out) |=> flush_req_out)
    else $error("no flush after link rise");
  AST_FLUSH_PULSE: assert property (flush_req_out |=> !flush_req_out)
    else $error("flush request longer than one cycle");
  AST_BLOCK_STOPS_EGRESS: assert property (fwd_block_out |=> !p3_rx_valid_out)
    else $error("nibble driven while bypassed");
  AST_RXV_NEEDS_READY: assert property ($rose(p3_rx_valid_out) |-> $past(eg_ready_out))
    else $error("receive valid without accepted nibble");
  AST_NIBBLE_SPACING: assert property (ing_valid_out |=> !ing_valid_out [*6])
    else $error("ingress nibbles closer than one clock period");
  AST_VALID_IN_FRAME: assert property (ing_valid_out |-> ing_frame_out)
    else $error("ingress nibble outside frame");
  AST_END_CLOSES: assert property (ing_end_out |-> !ing_frame_out && $past(ing_frame_out))
    else $error("frame end without open frame");
  AST_ERR_MAC_END: assert property ($rose(ing_error_out) |-> p3_tx_clock_oe_n_out && ing_end_out)
    else $error("frame error outside MAC mode frame end");
  AST_COL_HALF: assert property (!half_duplex_in [*3] |-> !port_collision_flag_out)
    else $error("collision flagged in full duplex");

  // Main scenarios
  COV_FLUSH: cover property (flush_req_out);
  COV_FRAME_END: cover property (ing_end_out && ing_error_out);
  COV_EGRESS: cover property ($rose(p3_rx_valid_out));
  COV_COLLISION: cover property (port_collision_flag_out);
endmodule

bind p3m_mii_port p3m_mii_port_chk i_p3m_mii_port_chk (
  .core_clk_in, .srst_in, .half_duplex_in, .p3_tx_clock_oe_n_out, .p3_rx_valid_out,
  .ing_valid_out, .ing_frame_out, .ing_end_out, .ing_error_out, .eg_ready_out,
  .fwd_block_out, .flush_req_out, .port_collision_flag_out
);

// ### testbench/p3m_far_end.sv
`timescale 1ns/1ps

// External MAC (PHY mode) or external PHY (MAC mode); its receive error is driven by the bench as tx_err
module p3m_far_end (
  // Mode and clocks seen on the wire
  input  wire logic        mode_mac_in,
  input  wire logic        tx_clk_in,
  input  wire logic        rx_clk_in,
  // Frame request
  input  wire logic        go_in,
  input  wire logic [15:0] nibs_in,
  // Nibbles from the device
  input  wire logic        rx_valid_in,
  input  wire logic [3:0]  rx_data_in,
  // Outputs
  output logic             clk_out,
  output logic             tx_en_out,
  output logic [3:0]       tx_data_out,
  output logic [15:0]      cap_out,
  output int               cap_cnt_out
);
  int   left;
  logic go_q;

  initial begin
    clk_out = 1'b0; tx_en_out = 1'b0; tx_data_out = 4'h0;
    cap_out = 16'h0; cap_cnt_out = 0; left = 0; go_q = 1'b0;
  end

  // Free running nibble clock only when this side is the PHY
  always #40 clk_out = mode_mac_in ? ~clk_out : 1'b0;

  // Drive on the fall so the device samples on the rise; idle data toggles
  always @(negedge tx_clk_in) begin
    go_q <= go_in;
    if (left != 0) begin
      tx_en_out   <= 1'b1;
      tx_data_out <= nibs_in[4*(4-left) +: 4];
      left        <= left - 1;
    end else begin
      tx_en_out   <= 1'b0;
      tx_data_out <= ~tx_data_out;
      if (go_in && !go_q) begin
        left <= 4;
      end
    end
  end

  always @(posedge rx_clk_in) begin
    if (rx_valid_in) begin
      cap_out     <= {rx_data_in, cap_out[15:4]};
      cap_cnt_out <= cap_cnt_out + 1;
    end
  end
endmodule

// ### testbench/p3m_mii_port_bench.sv
`timescale 1ns/1ps

module p3m_mii_port_bench;
  logic        clk, srst, mode_mac, half, tx_err, eg_valid, eg_last, go;
  logic [3:0]  eg_data, tx_d, rx_d;
  logic [15:0] fnibs, cap;
  logic        tx_en, far_clk, tx_clk_o, tx_clk_oe_n, rx_clk_o, rx_clk_oe_n, rx_valid;
  logic        col_o, col_oe_n, crs_o, crs_oe_n, ing_valid, ing_frame, ing_end, ing_error;
  logic        eg_ready, fwd_block, flush_req, col_flag, crs;
  logic [2:0]  col_seen;
  logic [3:0]  ing_data;
  int          cap_cnt, bad_count, checked, flush_cnt;

  p3m_mii_port i_p3m_mii_port (
    .core_clk_in(clk), .srst_in(srst), .mode_mac_in(mode_mac), .half_duplex_in(half),
    .p3_tx_enable_in(tx_en), .p3_tx_error_in(tx_err), .p3_tx_data_bit3_in(tx_d[3]),
    .p3_tx_data_bit2_in(tx_d[2]), .p3_tx_data_bit1_in(tx_d[1]), .p3_tx_data_bit0_in(tx_d[0]),
    .p3_tx_clock_in(tx_clk_oe_n ? far_clk : tx_clk_o), .p3_tx_clock_out(tx_clk_o),
    .p3_tx_clock_oe_n_out(tx_clk_oe_n), .p3_rx_valid_out(rx_valid),
    .p3_rx_data_bit3_out(rx_d[3]), .p3_rx_data_bit2_out(rx_d[2]),
    .p3_rx_data_bit1_out(rx_d[1]), .p3_rx_data_bit0_out(rx_d[0]),
    .p3_rx_clock_in(rx_clk_oe_n ? far_clk : rx_clk_o), .p3_rx_clock_out(rx_clk_o),
    .p3_rx_clock_oe_n_out(rx_clk_oe_n), .p3_collision_in(col_oe_n ? (tx_en & rx_valid) : col_o),
    .p3_collision_out(col_o), .p3_collision_oe_n_out(col_oe_n),
    .p3_carrier_sense_in(crs_oe_n ? tx_en : crs_o), .p3_carrier_sense_out(crs_o),
    .p3_carrier_sense_oe_n_out(crs_oe_n), .ing_valid_out(ing_valid), .ing_data_out(ing_data),
    .ing_frame_out(ing_frame), .ing_end_out(ing_end), .ing_error_out(ing_error),
    .eg_valid_in(eg_valid), .eg_data_in(eg_data), .eg_last_in(eg_last),
    .eg_ready_out(eg_ready), .fwd_block_out(fwd_block), .flush_req_out(flush_req),
    .port_collision_flag_out(col_flag), .carrier_sense_out(crs)
  );

  p3m_far_end i_p3m_far_end (
    .mode_mac_in(mode_mac), .tx_clk_in(tx_clk_oe_n ? far_clk : tx_clk_o),
    .rx_clk_in(rx_clk_oe_n ? far_clk : rx_clk_o), .go_in(go), .nibs_in(fnibs),
    .rx_valid_in(rx_valid), .rx_data_in(rx_d), .clk_out(far_clk), .tx_en_out(tx_en),
    .tx_data_out(tx_d), .cap_out(cap), .cap_cnt_out(cap_cnt)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Sticky flags sampled mid-cycle, so the tasks may clear them on the rising edge
  always @(negedge clk) begin
    col_seen <= col_seen | {crs === 1'b1, col_o === 1'b1, col_flag === 1'b1};
    if (flush_req === 1'b1) flush_cnt <= flush_cnt + 1;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      bad_count++;
      $display("ERROR wait expected done seen timeout");
      final_report();
    end
  endtask

  task automatic ingress(input logic [15:0] nibs, input logic err);
    logic [15:0] got;
    int          n;
    got = 16'h0;
    n = 0;
    go <= 1'b1;
    fnibs <= nibs;
    while (ing_end !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
      if (ing_valid === 1'b1) got = {ing_data, got[15:4]};
    end
    tmo(n, 400);
    @(posedge clk);
    go <= 1'b0;
    // The partner starts a frame only on a fresh request, so let it see the drop
    repeat (10) @(posedge clk);
    chk("ingress nibbles", nibs, got);
    chk("ingress error", {15'h0, err}, {15'h0, ing_error});
  endtask

  // Offer stands until ready is seen, then moves on at the next edge
  task automatic egress(input logic [15:0] nibs);
    int base;
    int n;
    base = cap_cnt;
    for (int i = 0; i < 4; i++) begin
      eg_valid <= 1'b1;
      eg_data  <= nibs[4*i +: 4];
      eg_last  <= (i == 3);
      n = 0;
      @(negedge clk);
      while (eg_ready !== 1'b1 && n < 100) begin
        n++;
        @(negedge clk);
      end
      tmo(n, 100);
      @(posedge clk);
    end
    eg_valid <= 1'b0;
    eg_last  <= 1'b0;
    n = 0;
    while (cap_cnt < base + 4 && n < 200) begin
      n++;
      @(posedge clk);
    end
    tmo(n, 200);
    chk("egress nibbles", nibs, cap);
  endtask

  task automatic t_collision();
    half <= 1'b1;
    col_seen <= 3'h0;
    fork
      ingress(16'h2d4b, 1'b0);
      egress(16'h8f1a);
    join
    chk("carrier, collision pin and flag", 16'h7, {13'h0, col_seen});
    half <= 1'b0;
  endtask

  task automatic t_bypass();
    int base;
    base = flush_cnt;
    tx_err <= 1'b1;
    repeat (10) @(posedge clk);
    eg_valid <= 1'b1;
    eg_data  <= 4'h6;
    eg_last  <= 1'b1;
    repeat (40) @(negedge clk);
    chk("link block", 16'h1, {15'h0, fwd_block});
    chk("flush pulses", 16'h1, 16'(flush_cnt - base));
    chk("ready while flushing", 16'h1, {15'h0, eg_ready});
    chk("valid while bypassed", 16'h0, {15'h0, rx_valid});
    @(posedge clk);
    tx_err   <= 1'b0;
    eg_valid <= 1'b0;
    eg_last  <= 1'b0;
    repeat (20) @(posedge clk);
  endtask

  // Error pin is the partner's receive error here, never a link status
  task automatic t_mac();
    mode_mac <= 1'b1;
    repeat (30) @(posedge clk);
    tx_err <= 1'b1;
    ingress(16'h5e07, 1'b1);
    chk("no bypass in MAC mode", 16'h0, {15'h0, fwd_block});
    tx_err <= 1'b0;
    ingress(16'hb3c9, 1'b0);
    egress(16'h4ad2);
    t_collision();
  endtask

  task automatic final_report();
    if (bad_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1; mode_mac = 1'b0; half = 1'b0; tx_err = 1'b0; eg_valid = 1'b0;
    eg_last = 1'b0; eg_data = 4'h0; go = 1'b0; fnibs = 16'h0; col_seen = 3'h0;
    bad_count = 0; checked = 0; flush_cnt = 0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    ingress(16'h93c6, 1'b0);
    egress(16'h7e18);
    t_collision();
    t_bypass();
    t_mac();
    final_report();
  end
endmodule
